/* logic/sleep_wake_pkg.sv */
// Constants, states and field layouts of the sleep, wake-up and watchdog block.
// Assumes one system clock; the low-speed RC clock arrives as a one-cycle enable.
package sleep_wake_pkg;
    localparam int unsigned sys_clk_hz = 25000000;
    localparam int unsigned start_up_sys_cycles = 16;
    localparam int unsigned reset_delay_ms = 50;
    localparam int unsigned reset_delay_cycles = (sys_clk_hz / 1000) * reset_delay_ms;
    localparam int unsigned start_up_cycles = start_up_sys_cycles;
    localparam int unsigned delay_width = 21;
    localparam logic [7:0] period_select_reset = 8'h07;
    localparam logic [7:0] voltage_reset_control_reset = 8'h00;
    localparam int unsigned period_lsb = 0;
    localparam int unsigned enable_code_lsb = 0;
    localparam int unsigned clock_select_lsb = 6;
    localparam int unsigned lvr_code_lsb = 3;
    localparam logic [2:0] enable_code_on = 3'h0;
    localparam logic [2:0] enable_code_off = 3'h5;
    localparam logic [1:0] clock_sel_low_speed_rc_clock = 2'h0;
    localparam logic [1:0] clock_sel_div4 = 2'h1;
    localparam int unsigned wdt_width = 15;
    localparam int unsigned tap_base = 8;
    localparam int unsigned timeout_flag_bit = 5;
    localparam int unsigned power_down_flag_bit = 4;

    typedef enum logic [3:0]
    {
        st_run = 4'b0001,
        st_sleep = 4'b0010,
        st_wait = 4'b0100,
        st_reset = 4'b1000
    } power_state_type;

    typedef enum logic [2:0]
    {
        wake_none = 3'h0,
        wake_reset = 3'h1,
        wake_port = 3'h2,
        wake_irq_resume = 3'h3,
        wake_irq_vector = 3'h4,
        wake_watchdog = 3'h5
    } wake_cause_type;
endpackage : sleep_wake_pkg

/* logic/wdt_core_if.sv */
// Carrier between the power sequencer and the watchdog counter.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
`default_nettype none
interface wdt_core_if;
    logic clear;
    logic count_en;
    logic [2:0] period;
    logic overflow;
    logic [14:0] count;

    modport ctrl
    (
        output clear,
        output count_en,
        output period,
        input overflow,
        input count
    );
    modport core
    (
        input clear,
        input count_en,
        input period,
        output overflow,
        output count
    );
endinterface : wdt_core_if
`default_nettype wire

/* logic/wdt_counter.sv */
// Watchdog up-counter with a selectable overflow tap.
// Assumes count_en already carries the selected source clock rate.
`timescale 1ns/1ps
`default_nettype none
module wdt_counter
    import sleep_wake_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    wdt_core_if.core wdt
);
    logic [14:0] count_r;
    logic [14:0] count_nxt;
    logic overflow_r;
    wire logic [15:0] tap_limit;
    wire logic hit;

    // Overflow at 2^(8+period) counts
    assign tap_limit = 16'h0001 << (tap_base + 32'(wdt.period));
    assign hit = wdt.count_en && ({1'b0, count_r} == (tap_limit - 16'h0001));
    assign count_nxt = wdt.clear || hit ? 15'h0000 : count_r + 15'(wdt.count_en);

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            count_r <= 15'h0000;
            overflow_r <= 1'b0;
        end
        else
        begin
            count_r <= count_nxt;
            overflow_r <= hit && !wdt.clear;
        end
    end

    assign wdt.count = count_r;
    assign wdt.overflow = overflow_r;

    wrap_zero_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        overflow_r |-> count_r == 15'h0000) else $error("count not restarted after overflow");
    clear_zero_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        wdt.clear |=> count_r == 15'h0000 && !overflow_r) else $error("clear did not zero counter");
endmodule : wdt_counter
`default_nettype wire

/* logic/sleep_wake_watchdog.sv */
// Power-down control, wake-up sequencing and watchdog of a small controller core.
// Assumes the core gives one-cycle strobes for instructions and register writes.
// Functional notes
// - Sleep instruction stops system clock and holds execution; only way into power-down.
// - Memory, registers and ports keep their values throughout power-down.
// - Sleep clears watchdog; counting continues in sleep on low-speed RC clock.
// - Sleep sets power-down flag and clears time-out flag.
// - Wake on external reset, enabled port A fall, interrupt or watchdog overflow.
// - External reset wake performs a full system reset.
// - Watchdog wake sets time-out flag, resets only program counter and stack.
// - Power-down flag cleared by power-up or clear-watchdog, set by sleep.
// - Eight port A wake enables; falling edge resumes after sleep instruction.
// - Disabled or stack-full interrupt wake resumes after sleep; request stays pending.
// - Enabled interrupt with stack room wakes into normal vectoring.
// - Interrupt flagged before sleep does not wake that sleep period.
// - Wake delay: reset delay plus 16 clocks for reset, else 16 clocks.
// - Clock select: 00 low-speed RC, 01 system/4, 10 and 11 system clock.
// - Period field gives 2^(8+n) source cycles; resets to all ones.
// - Enable code 000 enables, 101 disables, any other value resets device.
// - System-derived watchdog clock halts during sleep.
// - Overflow in normal run resets device and sets time-out flag.
// - Watchdog cleared by reset pin low, clear-watchdog or sleep.
// - Watchdog instructions are no-operations while watchdog is disabled.
// - Status writes never change time-out or power-down flags.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_watchdog
    import sleep_wake_pkg::*;
#(
    parameter int unsigned reset_delay_count = reset_delay_cycles
)
(
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic low_speed_rc_clock_tick_in,
    input wire logic external_reset_pin_in,
    input wire logic sleep_instruction_in,
    input wire logic clear_watchdog_instruction_in,
    input wire logic period_write_in,
    input wire logic control_write_in,
    input wire logic [7:0] write_data_in,
    input wire logic [7:0] port_a_in,
    input wire logic [7:0] port_a_wake_enable_in,
    input wire logic [7:0] irq_request_in,
    input wire logic [7:0] irq_enable_in,
    input wire logic stack_full_in,
    output logic [7:0] period_select_out,
    output logic [7:0] voltage_reset_control_out,
    output logic [1:0] status_flags_out,
    output logic sys_clk_enable_out,
    output logic core_hold_out,
    output logic system_reset_out,
    output logic pc_stack_reset_out,
    output logic irq_vector_out,
    output logic [14:0] watchdog_count_out
);
    import sleep_wake_pkg::*;

    wdt_core_if wdt ();

    power_state_type state_r;
    power_state_type state_nxt;
    wake_cause_type cause_r;
    wake_cause_type cause_nxt;
    logic [7:0] period_r;
    logic [7:0] control_r;
    logic timeout_flag_r;
    logic power_down_flag_r;
    logic [7:0] port_prev_r;
    logic [7:0] irq_at_sleep_r;
    logic [1:0] div4_r;
    logic [delay_width-1:0] delay_r;
    logic [delay_width-1:0] delay_nxt;
    logic wdt_enabled_r;
    logic sys_clk_enable_r;
    logic hold_r;
    logic sys_reset_r;
    logic pc_reset_r;
    logic vector_r;
    logic reset_pin_prev_r;

    function automatic logic code_is_bad(input logic [2:0] code);
        return code != enable_code_on && code != enable_code_off;
    endfunction : code_is_bad

    // Decode
    wire logic [2:0] enable_code = control_r[enable_code_lsb +: 3];
    wire logic [1:0] clock_sel = control_r[clock_select_lsb +: 2];
    wire logic [2:0] write_enable_code = write_data_in[enable_code_lsb +: 3];
    wire logic asleep = state_r == st_sleep;
    wire logic running = state_r == st_run;
    wire logic sleep_go = running && sleep_instruction_in;
    wire logic clear_go = running && clear_watchdog_instruction_in && wdt_enabled_r;
    wire logic bad_code_write = control_write_in && running && code_is_bad(write_enable_code);
    wire logic reset_pin_fall = reset_pin_prev_r && !external_reset_pin_in;
    wire logic div4_tick = div4_r == 2'h3;
    // Core clocks stop in sleep; only the low-speed RC keeps the count going
    wire logic tick_sel = clock_sel == clock_sel_low_speed_rc_clock ? low_speed_rc_clock_tick_in :
        clock_sel == clock_sel_div4 ? div4_tick && !asleep : !asleep;
    wire logic port_wake = |(port_prev_r & ~port_a_in & port_a_wake_enable_in);
    wire logic [7:0] fresh_irq = irq_request_in & ~irq_at_sleep_r;
    wire logic irq_wake = |fresh_irq;
    wire logic irq_serviceable = |(fresh_irq & irq_enable_in) && !stack_full_in;
    wire logic wdt_over = wdt.overflow && wdt_enabled_r;

    assign wdt.clear = sleep_go || clear_go || !external_reset_pin_in;
    assign wdt.count_en = tick_sel && wdt_enabled_r;
    assign wdt.period = period_r[period_lsb +: 3];

    wdt_counter u_counter
    (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .wdt(wdt)
    );

    // Wake sources and their priority; reset pin outranks all
    always_comb
    begin
        state_nxt = state_r;
        cause_nxt = cause_r;
        delay_nxt = delay_r;
        case (state_r)
            st_run:
            begin
                cause_nxt = wake_none;
                if (reset_pin_fall || bad_code_write || wdt_over)
                begin
                    state_nxt = st_reset;
                    cause_nxt = wake_reset;
                    delay_nxt = delay_width'(reset_delay_count + start_up_cycles);
                end
                else if (sleep_go)
                    state_nxt = st_sleep;
            end
            st_sleep:
            begin
                if (!external_reset_pin_in)
                begin
                    state_nxt = st_reset;
                    cause_nxt = wake_reset;
                    delay_nxt = delay_width'(reset_delay_count + start_up_cycles);
                end
                else if (wdt_over || port_wake || irq_wake)
                begin
                    state_nxt = st_wait;
                    delay_nxt = delay_width'(start_up_cycles);
                    if (wdt_over)
                        cause_nxt = wake_watchdog;
                    else if (port_wake)
                        cause_nxt = wake_port;
                    else if (irq_serviceable)
                        cause_nxt = wake_irq_vector;
                    else
                        cause_nxt = wake_irq_resume;
                end
            end
            st_wait, st_reset:
            begin
                // Pin low during a short wake delay escalates to a full reset
                if (!external_reset_pin_in)
                begin
                    state_nxt = st_reset;
                    cause_nxt = wake_reset;
                    delay_nxt = delay_width'(reset_delay_count + start_up_cycles);
                end
                else if (delay_r != '0)
                    delay_nxt = delay_r - delay_width'(1);
                if (delay_r == delay_width'(1) && external_reset_pin_in)
                    state_nxt = st_run;
            end
            default:
            begin
                state_nxt = st_run;
                cause_nxt = wake_none;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            state_r <= st_run;
            cause_r <= wake_none;
            delay_r <= '0;
            div4_r <= 2'h0;
            port_prev_r <= 8'hff;
            reset_pin_prev_r <= 1'b1;
            irq_at_sleep_r <= 8'h00;
        end
        else
        begin
            state_r <= state_nxt;
            cause_r <= cause_nxt;
            delay_r <= delay_nxt;
            div4_r <= asleep ? div4_r : div4_r + 2'h1;
            port_prev_r <= port_a_in;
            reset_pin_prev_r <= external_reset_pin_in;
            if (sleep_go)
                irq_at_sleep_r <= irq_request_in;
        end
    end

    // Registers survive sleep; a device reset restores their reset values
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            period_r <= period_select_reset;
            control_r <= voltage_reset_control_reset;
            wdt_enabled_r <= 1'b1;
        end
        else if (state_r == st_reset && cause_r == wake_reset && delay_r == delay_width'(1))
        begin
            period_r <= period_select_reset;
            control_r <= voltage_reset_control_reset;
            wdt_enabled_r <= 1'b1;
        end
        else if (running)
        begin
            if (period_write_in)
                period_r <= {5'h00, write_data_in[period_lsb +: 3]};
            if (control_write_in)
                control_r <= write_data_in;
            if (control_write_in && write_enable_code == enable_code_off)
                wdt_enabled_r <= 1'b0;
            else if (control_write_in && write_enable_code == enable_code_on)
                wdt_enabled_r <= 1'b1;
        end
    end

    // Flags move only on these events, never on status writes
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            timeout_flag_r <= 1'b0;
            power_down_flag_r <= 1'b0;
        end
        else if (wdt_over)
            timeout_flag_r <= 1'b1;
        else if (sleep_go)
        begin
            timeout_flag_r <= 1'b0;
            power_down_flag_r <= 1'b1;
        end
        else if (clear_go)
        begin
            timeout_flag_r <= 1'b0;
            power_down_flag_r <= 1'b0;
        end
    end

    // Output stage, every output registered
    always_ff @(posedge sys_clk_in or negedge resetn_in)
    begin
        if (!resetn_in)
        begin
            sys_clk_enable_r <= 1'b1;
            hold_r <= 1'b0;
            sys_reset_r <= 1'b0;
            pc_reset_r <= 1'b0;
            vector_r <= 1'b0;
        end
        else
        begin
            sys_clk_enable_r <= state_nxt != st_sleep;
            hold_r <= state_nxt != st_run;
            sys_reset_r <= state_nxt == st_reset;
            pc_reset_r <= state_r == st_wait && state_nxt == st_run && cause_r == wake_watchdog;
            vector_r <= state_r == st_wait && state_nxt == st_run && cause_r == wake_irq_vector;
        end
    end

    assign period_select_out = period_r;
    assign voltage_reset_control_out = control_r;
    assign status_flags_out = {timeout_flag_r, power_down_flag_r};
    assign sys_clk_enable_out = sys_clk_enable_r;
    assign core_hold_out = hold_r;
    assign system_reset_out = sys_reset_r;
    assign pc_stack_reset_out = pc_reset_r;
    assign irq_vector_out = vector_r;
    assign watchdog_count_out = wdt.count;

    sequence wake_seen_s;
        asleep && external_reset_pin_in && (port_wake || irq_wake) && !wdt_over;
    endsequence
    sequence short_delay_s;
        hold_r && !sys_reset_r;
    endsequence

    sleep_stops_clock_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        sleep_go |=> !sys_clk_enable_r && hold_r) else $error("sleep did not stop clock");
    sleep_flags_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        sleep_go && !wdt_over |=> power_down_flag_r && !timeout_flag_r) else $error("sleep flags wrong");
    regs_kept_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        asleep |=> $stable(period_r) && $stable(control_r)) else $error("registers changed in sleep");
    wake_delay_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        wake_seen_s |=> short_delay_s [*8] ##[1:9] !hold_r) else $error("wake delay wrong");
    pin_reset_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        asleep && !external_reset_pin_in |=> sys_reset_r) else $error("pin wake not full reset");
    wdt_flag_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        wdt_over |=> timeout_flag_r) else $error("timeout flag not set");
    halt_in_sleep_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        asleep && clock_sel != clock_sel_low_speed_rc_clock |-> !wdt.count_en) else $error("system clock counted in sleep");
    disabled_noop_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !wdt_enabled_r && clear_watchdog_instruction_in && running
        |=> $stable(power_down_flag_r)) else $error("clear acted while disabled");
    bad_code_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        bad_code_write |=> sys_reset_r) else $error("bad enable code did not reset");
    port_resume_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        asleep && external_reset_pin_in && !wdt_over && port_wake
        |=> cause_r == wake_port) else $error("port wake not taken");

    sequence reset_end_s;
        sys_reset_r ##1 !sys_reset_r;
    endsequence

    // Core acts on the pulse edge, so a stretched pulse would repeat it
    pc_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        pc_reset_r |=> !pc_reset_r) else $error("pc reset pulse too long");
    vector_pulse_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        vector_r |=> !vector_r) else $error("vector pulse too long");

    no_source_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        asleep && external_reset_pin_in && !wdt_over && !port_wake && !irq_wake
        |=> asleep) else $error("woke without a source");

    reset_restore_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        reset_end_s |-> period_r == period_select_reset) else $error("reset left period");

    flags_kept_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !wdt_over && !sleep_go && !clear_go
        |=> $stable(timeout_flag_r) && $stable(power_down_flag_r)) else $error("flags moved");

    clear_flags_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        clear_go && !wdt_over |=> !power_down_flag_r && !timeout_flag_r) else $error("clear kept flags");
endmodule : sleep_wake_watchdog
`default_nettype wire

/* testbench/sleep_wake_watchdog_test.sv */
// Self-checking bench for the sleep, wake-up and watchdog block.
// Assumes the shortened reset delay below; instruction and write strobes are single-cycle pulses, the low-speed tick is also held high.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_watchdog_test;
    import sleep_wake_pkg::*;
    localparam int unsigned short_delay = 20;
    // Full reset holds the core for the delay plus the start-up time
    localparam int unsigned full_hold = short_delay + start_up_sys_cycles;
    logic sys_clk_in, resetn_in, low_speed_rc_clock_tick_in, external_reset_pin_in;
    logic sleep_instruction_in, clear_watchdog_instruction_in, period_write_in, control_write_in;
    logic [7:0] write_data_in, port_a_in, port_a_wake_enable_in, irq_request_in, irq_enable_in;
    logic stack_full_in;
    logic [7:0] period_select_out, voltage_reset_control_out;
    logic [1:0] status_flags_out;
    logic sys_clk_enable_out, core_hold_out, system_reset_out, pc_stack_reset_out, irq_vector_out;
    logic [14:0] watchdog_count_out;
    int n_mismatch, tests_run, en_hold, rst_len, saw_pc, saw_vec, c0;

    sleep_wake_watchdog #(.reset_delay_count(short_delay)) dut
    (
        .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .low_speed_rc_clock_tick_in(low_speed_rc_clock_tick_in),
        .external_reset_pin_in(external_reset_pin_in), .sleep_instruction_in(sleep_instruction_in),
        .clear_watchdog_instruction_in(clear_watchdog_instruction_in),
        .period_write_in(period_write_in), .control_write_in(control_write_in),
        .write_data_in(write_data_in), .port_a_in(port_a_in), .port_a_wake_enable_in(port_a_wake_enable_in),
        .irq_request_in(irq_request_in), .irq_enable_in(irq_enable_in), .stack_full_in(stack_full_in),
        .period_select_out(period_select_out), .voltage_reset_control_out(voltage_reset_control_out),
        .status_flags_out(status_flags_out), .sys_clk_enable_out(sys_clk_enable_out),
        .core_hold_out(core_hold_out), .system_reset_out(system_reset_out),
        .pc_stack_reset_out(pc_stack_reset_out), .irq_vector_out(irq_vector_out),
        .watchdog_count_out(watchdog_count_out)
    );

    initial
    begin
        sys_clk_in = 1'b0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    task automatic complete_run;
        if (n_mismatch == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : complete_run

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check

    // Inputs move 1 ns after the edge so the design samples settled values
    task automatic tick(input int n = 1);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask : tick

    task automatic do_sleep;
        sleep_instruction_in = 1'b1;
        tick();
        sleep_instruction_in = 1'b0;
    endtask : do_sleep

    task automatic do_clear;
        clear_watchdog_instruction_in = 1'b1;
        tick();
        clear_watchdog_instruction_in = 1'b0;
    endtask : do_clear

    task automatic write_reg(input logic sel_ctrl, input logic [7:0] d);
        write_data_in = d;
        period_write_in = ~sel_ctrl;
        control_write_in = sel_ctrl;
        tick();
        period_write_in = 1'b0;
        control_write_in = 1'b0;
    endtask : write_reg

    // Bounded wait until the core runs again, tallying what happened meanwhile
    task automatic watch(input int bound);
        int i;
        en_hold = 0;
        rst_len = 0;
        saw_pc = 0;
        saw_vec = 0;
        for (i = 0; i < bound; i++)
        begin
            if (sys_clk_enable_out === 1'b1 && core_hold_out === 1'b1)
                en_hold++;
            if (system_reset_out === 1'b1)
                rst_len++;
            if (pc_stack_reset_out === 1'b1)
                saw_pc++;
            if (irq_vector_out === 1'b1)
                saw_vec++;
            if (core_hold_out === 1'b0 && system_reset_out === 1'b0 && i > 0)
                break;
            tick();
        end
        if (i == bound)
        begin
            check("wake wait", 1, 0);
            complete_run();
        end
    endtask : watch

    task automatic wait_reset(input int bound);
        int i;
        for (i = 0; i < bound && system_reset_out !== 1'b1; i++)
            tick();
        if (i == bound)
        begin
            check("reset wait", 1, 0);
            complete_run();
        end
    endtask : wait_reset

    task automatic port_wake(input int exp_hold);
        port_a_in = 8'hf3;
        watch(100);
        check("port wake delay", exp_hold, en_hold);
        port_a_in = 8'hff;
        tick();
    endtask : port_wake

    initial
    begin
        n_mismatch = 0;
        tests_run = 0;
        resetn_in = 1'b0;
        low_speed_rc_clock_tick_in = 1'b0;
        external_reset_pin_in = 1'b1;
        sleep_instruction_in = 1'b0;
        clear_watchdog_instruction_in = 1'b0;
        period_write_in = 1'b0;
        control_write_in = 1'b0;
        write_data_in = 8'h00;
        port_a_in = 8'hff;
        port_a_wake_enable_in = 8'h08;
        irq_request_in = 8'h00;
        irq_enable_in = 8'h00;
        stack_full_in = 1'b0;
        tick(4);
        resetn_in = 1'b1;
        check("period reset", 8'h07, period_select_out);
        check("control reset", 8'h00, voltage_reset_control_out);
        check("flags reset", 2'b00, status_flags_out);
        check("clock on", 1'b1, sys_clk_enable_out);
        // Sleep, ignore a disabled pin, wake on the enabled one
        write_reg(1'b0, 8'h05);
        do_sleep();
        check("clock stop", 1'b0, sys_clk_enable_out);
        check("hold", 1'b1, core_hold_out);
        check("sleep flags", 2'b01, status_flags_out);
        check("sleep count", 15'h0, watchdog_count_out);
        port_a_in = 8'hfb;
        tick(5);
        check("no wake disabled pin", 1'b1, core_hold_out);
        port_wake(start_up_sys_cycles);
        check("port no vector", 0, saw_vec + saw_pc);
        check("kept period", 8'h05, period_select_out);
        check("kept flags", 2'b01, status_flags_out);
        do_clear();
        check("clear flags", 2'b00, status_flags_out);
        // Interrupts: stale request ignored, then vectoring wake
        irq_request_in = 8'h01;
        irq_enable_in = 8'h03;
        do_sleep();
        tick(6);
        check("stale irq", 1'b1, core_hold_out);
        irq_request_in = 8'h03;
        watch(100);
        check("irq delay", start_up_sys_cycles, en_hold);
        check("irq vector", 1, saw_vec);
        for (int k = 0; k < 2; k++)
        begin
            irq_request_in = 8'h00;
            irq_enable_in = (k == 0) ? 8'h00 : 8'h04;
            stack_full_in = (k == 1);
            tick();
            do_sleep();
            irq_request_in = 8'h04;
            watch(100);
            check("irq resume", 0, saw_vec);
            check("irq resume wake", start_up_sys_cycles, en_hold);
        end
        irq_request_in = 8'h00;
        stack_full_in = 1'b0;
        // Clock select rates: system, system/4, system, low-speed ticks
        for (int k = 0; k < 3; k++)
        begin
            write_reg(1'b1, (k == 1) ? 8'h40 : ((k == 0) ? 8'h80 : 8'hc0));
            do_clear();
            c0 = watchdog_count_out;
            tick(8);
            check("count rate", (k == 1) ? 2 : 8, watchdog_count_out - c0);
        end
        write_reg(1'b1, 8'h00);
        c0 = watchdog_count_out;
        for (int k = 0; k < 3; k++)
        begin
            low_speed_rc_clock_tick_in = 1'b1;
            tick();
            low_speed_rc_clock_tick_in = 1'b0;
            tick();
        end
        check("low_speed_rc_clock rate", 3, watchdog_count_out - c0);
        // System clock source halts in sleep
        write_reg(1'b1, 8'h80);
        tick(5);
        do_sleep();
        tick(8);
        check("halted count", 15'h0, watchdog_count_out);
        port_wake(start_up_sys_cycles);
        // Watchdog overflow in sleep on the low-speed clock, shortest period
        write_reg(1'b1, 8'h00);
        write_reg(1'b0, 8'h00);
        do_clear();
        do_sleep();
        low_speed_rc_clock_tick_in = 1'b1;
        tick(250);
        check("still asleep", 1'b1, core_hold_out);
        watch(100);
        low_speed_rc_clock_tick_in = 1'b0;
        check("wdt wake pc", 1, saw_pc);
        check("wdt wake flags", 2'b11, status_flags_out);
        check("wdt wake full", 0, rst_len);
        check("wdt wake delay", start_up_sys_cycles, en_hold);
        // Disabled watchdog ignores clear
        write_reg(1'b1, 8'h05);
        do_clear();
        check("disabled clear", 2'b11, status_flags_out);
        write_reg(1'b1, 8'h00);
        do_clear();
        check("enabled clear", 2'b00, status_flags_out);
        // Run-time overflow on system clock
        write_reg(1'b1, 8'h80);
        wait_reset(400);
        watch(200);
        check("overflow reset", full_hold, rst_len);
        check("overflow flags", 2'b10, status_flags_out);
        check("overflow period", 8'h07, period_select_out);
        check("overflow control", 8'h00, voltage_reset_control_out);
        // Illegal enable code resets the device
        write_reg(1'b0, 8'h02);
        write_reg(1'b1, 8'h03);
        wait_reset(10);
        watch(200);
        check("bad code reset", full_hold, rst_len);
        check("bad code period", 8'h07, period_select_out);
        // External reset pin wakes with a full reset
        do_sleep();
        external_reset_pin_in = 1'b0;
        tick();
        external_reset_pin_in = 1'b1;
        watch(200);
        check("pin wake reset", 1, rst_len > 0);
        check("pin wake delay", full_hold, en_hold);
        check("pin wake count", 1, watchdog_count_out < 15'h3);
        complete_run();
    end
endmodule : sleep_wake_watchdog_test
`default_nettype wire
